// ==== hdl/ssw_regs.vh ====
// constants for the supply supervisor and watchdog reset block
// assumes a 50 MHz system clock and a 32-bit avalon-mm register bus
`ifndef SSW_REGS_VH
`define SSW_REGS_VH

// clock and times
`define SSW_CLK_HZ        50000000
`define SSW_CYC_PER_MS    (`SSW_CLK_HZ / 1000)
`define SSW_T_HOLD_MS     250
`define SSW_T_HOLD_ALT_MS 200
`define SSW_T_WD0_MS      1400
`define SSW_T_WD1_MS      600
`define SSW_T_WD2_MS      200

// register byte offsets
`define SSW_OFS_CTRL      8'h00
`define SSW_OFS_STAT      8'h04
`define SSW_OFS_INT_STAT  8'h08
`define SSW_OFS_INT_EN    8'h0C
`define SSW_OFS_INT_CLR   8'h10

// control register fields
`define SSW_CTRL_SEL_LO   0
`define SSW_CTRL_SEL_HI   1
`define SSW_CTRL_PPE      2
`define SSW_CTRL_RST      3'h3

// timeout select codes
`define SSW_SEL_1400      2'h0
`define SSW_SEL_600       2'h1
`define SSW_SEL_200       2'h2
`define SSW_SEL_OFF       2'h3

// status register fields
`define SSW_STAT_RST      0
`define SSW_STAT_SUP      1
`define SSW_STAT_WD       2
`define SSW_STAT_WP       3

// interrupt event bits
`define SSW_EV_SUP_LOW    0
`define SSW_EV_WD_TMO     1
`define SSW_EV_RELEASE    2
`define SSW_EV_WR_REJ     3
`define SSW_EV_N          4

`endif

// ==== hdl/ssw_sync2.v ====
// two flip-flop synchroniser for a bundle of independent levels
// assumes each bit is a slow level; no bus coherence across bits
module ssw_sync2 #(
	parameter W = 1
) (
	input  wire         clk_sys,
	input  wire         rst_n,
	input  wire [W-1:0] async_i,
	output wire [W-1:0] sync_o
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// first stage feeds only the second stage
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule

// ==== hdl/ssw_irq.v ====
// sticky event status, enable mask and write-one-to-clear
// assumes event and clear strobes are one-cycle pulses on clk_sys
module ssw_irq #(
	parameter N = 4
) (
	input  wire         clk_sys,
	input  wire         rst_n,
	input  wire [N-1:0] event_i,
	input  wire [N-1:0] clear_i,
	input  wire [N-1:0] enable_i,
	output wire [N-1:0] status_o,
	output wire         irq_o
);
	reg [N-1:0] status_q;
	genvar i;

	// set beats clear so an event in the clearing cycle is kept
	generate
		for (i = 0; i < N; i = i + 1) begin : g_bit
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n)
					status_q[i] <= 1'b0;
				else if (event_i[i])
					status_q[i] <= 1'b1;
				else if (clear_i[i])
					status_q[i] <= 1'b0;
			end
		end
	endgenerate

	assign status_o = status_q;
	assign irq_o    = |(status_q & enable_i);
endmodule

// ==== hdl/ssw_top.v ====
// supply supervisor: timed reset generator, start-condition watchdog,
// serial memory port gating and an avalon-mm register slave
// assumes pins and the supply comparator are asynchronous to clk_sys,
// and that clk_sys stands in for the internal oscillator
//
// Our own choices: the Avalon-MM register port and the address map.
`include "ssw_regs.vh"

module ssw_top #(
	parameter        ACTIVE_HIGH = 0,
	parameter [31:0] HOLD_CYC    = `SSW_T_HOLD_MS * `SSW_CYC_PER_MS,
	parameter [31:0] WD0_CYC     = `SSW_T_WD0_MS * `SSW_CYC_PER_MS,
	parameter [31:0] WD1_CYC     = `SSW_T_WD1_MS * `SSW_CYC_PER_MS,
	parameter [31:0] WD2_CYC     = `SSW_T_WD2_MS * `SSW_CYC_PER_MS
) (
	input  wire        clk_sys,
	input  wire        rst_n,
	// avalon-mm slave
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	output wire        irq,
	// pins and comparator
	input  wire        supply_ok_i,
	input  wire        scl_i,
	input  wire        sda_i,
	input  wire        wp_i,
	output wire        reset_pin_o,
	output wire        reset_pin_oe,
	// serial memory port gate
	output wire        mem_access_en,
	output reg         mem_abort
);
	localparam ST_HOLD = 1'b0;
	localparam ST_RUN  = 1'b1;

	// hold time must lie in the documented band
	localparam [31:0] HOLD_MIN = `SSW_T_HOLD_ALT_MS * `SSW_CYC_PER_MS;

	wire [2:0]  pin_s;
	wire        sup_s;
	wire        scl_s;
	wire        sda_s;
	wire        wp_s;
	reg         sda_prev_q;
	wire        start_cond;

	reg         state_q;
	reg         state_d;
	reg  [31:0] hold_cnt_q;
	reg  [31:0] hold_cnt_d;
	reg  [31:0] wd_cnt_q;
	reg  [31:0] wd_cnt_d;
	wire        wd_on;
	wire [31:0] wd_limit;
	wire        wd_tmo;

	reg  [2:0]  ctrl_q;
	reg         ack_q;
	wire        req;
	wire        wr_take;
	wire        ctrl_wr;
	wire        ctrl_rej;
	wire        reset_act;

	reg  [`SSW_EV_N-1:0] int_en_q;
	wire [`SSW_EV_N-1:0] int_clr;
	wire [`SSW_EV_N-1:0] int_stat;
	wire [`SSW_EV_N-1:0] events;

	// timeout length for a select code, used by the watchdog limit only
	function [31:0] wd_len;
		input [1:0] sel;
		begin
			case (sel)
				`SSW_SEL_1400: wd_len = WD0_CYC;
				`SSW_SEL_600:  wd_len = WD1_CYC;
				`SSW_SEL_200:  wd_len = WD2_CYC;
				default:       wd_len = 32'h0000_0000;
			endcase
		end
	endfunction

	// supply, scl, sda and wp all come from outside this clock
	ssw_sync2 #(
		.W (3)
	) u_sync_pins (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.async_i ({wp_i, sda_i, scl_i}),
		.sync_o  (pin_s)
	);

	ssw_sync2 #(
		.W (1)
	) u_sync_sup (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.async_i (supply_ok_i),
		.sync_o  (sup_s)
	);

	assign scl_s = pin_s[0];
	assign sda_s = pin_s[1];
	assign wp_s  = pin_s[2];

	// previous sda sample for the edge detector, after the synchroniser
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			sda_prev_q <= 1'b1;
		else
			sda_prev_q <= sda_s;
	end

	// start condition: sda falls while scl is high
	assign start_cond = scl_s & sda_prev_q & ~sda_s;

	// select code decodes to a cycle count, 11 turns the dog off
	assign wd_limit = wd_len(ctrl_q[`SSW_CTRL_SEL_HI:`SSW_CTRL_SEL_LO]);
	assign wd_on    = (ctrl_q[`SSW_CTRL_SEL_HI:`SSW_CTRL_SEL_LO] != `SSW_SEL_OFF);

	// expiry when the bus has been idle for the full window
	assign wd_tmo = wd_on && (state_q == ST_RUN) && (wd_cnt_q >= wd_limit - 32'h0000_0001);

	// reset sequencer: hold until supply is good for the whole hold time
	always @* begin
		state_d    = state_q;
		hold_cnt_d = hold_cnt_q;
		wd_cnt_d   = wd_cnt_q;
		case (state_q)
			ST_HOLD: begin
				wd_cnt_d = 32'h0000_0000;
				if (!sup_s) begin
					hold_cnt_d = 32'h0000_0000;               // any dip restarts the wait
				end else if (hold_cnt_q >= HOLD_CYC - 32'h0000_0001) begin
					hold_cnt_d = 32'h0000_0000;
					state_d    = ST_RUN;                       // release after hold time
				end else begin
					hold_cnt_d = hold_cnt_q + 32'h0000_0001;
				end
			end
			ST_RUN: begin
				hold_cnt_d = 32'h0000_0000;
				if (!sup_s) begin
					state_d  = ST_HOLD;                        // low supply asserts reset
					wd_cnt_d = 32'h0000_0000;
				end else if (wd_tmo) begin
					state_d  = ST_HOLD;                        // watchdog expiry asserts reset
					wd_cnt_d = 32'h0000_0000;
				end else if (start_cond || !wd_on) begin
					wd_cnt_d = 32'h0000_0000;                  // restart from zero
				end else begin
					wd_cnt_d = wd_cnt_q + 32'h0000_0001;
				end
			end
			default: begin
				state_d    = ST_HOLD;
				hold_cnt_d = 32'h0000_0000;
				wd_cnt_d   = 32'h0000_0000;
			end
		endcase
	end

	// power-up starts in hold with reset active
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q    <= ST_HOLD;
			hold_cnt_q <= 32'h0000_0000;
			wd_cnt_q   <= 32'h0000_0000;
		end else begin
			state_q    <= state_d;
			hold_cnt_q <= hold_cnt_d;
			wd_cnt_q   <= wd_cnt_d;
		end
	end

	assign reset_act = (state_q == ST_HOLD);

	// open drain: only ever pull low; the high level (inactive unless ACTIVE_HIGH) comes from the pull-up
	assign reset_pin_o  = 1'b0;
	assign reset_pin_oe = ACTIVE_HIGH ? ~reset_act : reset_act;

	// memory port closed for the whole reset, including power-up
	assign mem_access_en = ~reset_act;

	// one-cycle abort when a running system is thrown into reset
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			mem_abort <= 1'b0;
		else
			mem_abort <= (state_q == ST_RUN) && (state_d == ST_HOLD);
	end

	// bus: one wait cycle on every access, then the answer
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign wr_take         = avs_write & ack_q;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	// control writes are locked out by the protect pin plus its enable
	assign ctrl_wr  = wr_take && (avs_address == `SSW_OFS_CTRL);
	assign ctrl_rej = ctrl_wr && wp_s && ctrl_q[`SSW_CTRL_PPE];

	// select bits are not touched by supply or watchdog resets;
	// only rst_n, standing in for the stored default, reloads them
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ctrl_q <= `SSW_CTRL_RST;
		else if (ctrl_wr && !ctrl_rej)
			ctrl_q <= avs_writedata[2:0];
	end

	// interrupt enable register
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			int_en_q <= {`SSW_EV_N{1'b0}};
		else if (wr_take && (avs_address == `SSW_OFS_INT_EN))
			int_en_q <= avs_writedata[`SSW_EV_N-1:0];
	end

	assign int_clr = (wr_take && (avs_address == `SSW_OFS_INT_CLR)) ?
	                 avs_writedata[`SSW_EV_N-1:0] : {`SSW_EV_N{1'b0}};

	// event pulses from the sequencer and the write path
	assign events[`SSW_EV_SUP_LOW] = (state_q == ST_RUN) && !sup_s;
	assign events[`SSW_EV_WD_TMO]  = (state_q == ST_RUN) && sup_s && wd_tmo;
	assign events[`SSW_EV_RELEASE] = (state_q == ST_HOLD) && (state_d == ST_RUN);
	assign events[`SSW_EV_WR_REJ]  = ctrl_rej;

	ssw_irq #(
		.N (`SSW_EV_N)
	) u_irq (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.event_i  (events),
		.clear_i  (int_clr),
		.enable_i (int_en_q),
		.status_o (int_stat),
		.irq_o    (irq)
	);

	// read data loaded in the wait cycle and held through the answer;
	// unmapped and write-only offsets read zero
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !ack_q) begin
			case (avs_address)
				`SSW_OFS_CTRL:     avs_readdata <= {29'h0000_0000, ctrl_q};
				`SSW_OFS_STAT:     avs_readdata <= {28'h000_0000, wp_s,
				                                    wd_on & ~reset_act, sup_s, reset_act};
				`SSW_OFS_INT_STAT: avs_readdata <= {28'h000_0000, int_stat};
				`SSW_OFS_INT_EN:   avs_readdata <= {28'h000_0000, int_en_q};
				default:           avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// HOLD_MIN documents the lower end of the allowed hold band
	wire hold_in_band = (HOLD_CYC >= HOLD_MIN);
endmodule

// ==== verif/ssw_top_properties.sv ====
// port-level checks for the supply supervisor
// assumes ACTIVE_HIGH=0: reset_pin_oe high means reset is asserted
module ssw_top_chk #(
	parameter [31:0] HOLD_CYC = 32'h0000_00C8,
	parameter [31:0] WD2_CYC  = 32'h0000_012C
) (
	input logic        clk_sys,
	input logic        rst_n,
	input logic [7:0]  avs_address,
	input logic        avs_read,
	input logic        avs_write,
	input logic [31:0] avs_readdata,
	input logic        avs_waitrequest,
	input logic        supply_ok_i,
	input logic        scl_i,
	input logic        sda_i,
	input logic        reset_pin_o,
	input logic        reset_pin_oe,
	input logic        mem_access_en,
	input logic        mem_abort
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] good_q;
	logic [31:0] since_q;
	logic        sda_q;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// raw pin history; the dut sees pins later, so these counts never lag it
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			good_q  <= 32'h0000_0000;
			since_q <= 32'h0000_0000;
			sda_q   <= 1'h1;
		end else begin
			good_q  <= supply_ok_i ? good_q + 32'h0000_0001 : 32'h0000_0000;
			since_q <= (scl_i && sda_q && !sda_i) ? 32'h0000_0000 : since_q + 32'h0000_0001;
			sda_q   <= sda_i;
		end
	end
	// reset timing and the pin itself
	chk_supply_low: assert property (!supply_ok_i [*3] |=> reset_pin_oe)
		else $error("no reset after supply loss");
	chk_pin_data: assert property (reset_pin_o == 1'h0)
		else $error("reset pin data not low");
	chk_release_hold: assert property ($fell(reset_pin_oe) |-> good_q >= HOLD_CYC)
		else $error("reset released early");
	chk_wd_limit: assert property ($rose(reset_pin_oe) |-> good_q < 32'h0000_0008 || since_q >= WD2_CYC)
		else $error("watchdog fired early");
	// memory port gating
	chk_mem_gate: assert property (mem_access_en == !reset_pin_oe)
		else $error("memory port open in reset");
	chk_abort_entry: assert property ($rose(reset_pin_oe) |-> ##[0:1] mem_abort)
		else $error("no abort on reset entry");
	chk_abort_single: assert property (mem_abort |=> !mem_abort)
		else $error("abort longer than one cycle");
	// register bus answers
	chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus wait too long");
	chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 8'h14 |-> avs_readdata == 0)
		else $error("unmapped read not zero");
endmodule

bind ssw_top ssw_top_chk #(.HOLD_CYC(HOLD_CYC), .WD2_CYC(WD2_CYC)) i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .supply_ok_i(supply_ok_i), .scl_i(scl_i), .sda_i(sda_i),
	.reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe), .mem_access_en(mem_access_en), .mem_abort(mem_abort));

// ==== verif/ssw_host_model.sv ====
// host model: drives the two-wire clock and data seen by the watchdog
// assumes pull-ups, so both lines rest high between frames
module ssw_host_model (
	input  logic clk_sys,
	output logic scl,
	output logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus sits at the pull-up level
	initial begin
		scl = 1'h1;
		sda = 1'h1;
	end
	// start condition at a 160 ns link period, then back to idle
	// each phase lasts two system clocks, so one link period is 160 ns
	task automatic send_start();
		sda <= 1'h0;
		repeat (2) @(posedge clk_sys);
		scl <= 1'h0;
		repeat (2) @(posedge clk_sys);
		sda <= 1'h1;
		repeat (2) @(posedge clk_sys);
		scl <= 1'h1;
		repeat (2) @(posedge clk_sys);
	endtask
endmodule

// ==== verif/tb_top.sv ====
// bench: power-up, supply loss, watchdog timeouts and write protect
// assumes shortened counts; the host model drives the two-wire pins
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD = 200;
	localparam int WD0  = 900;
	logic        clk_sys = 1'h0;
	logic        rst_n = 1'h0;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'h0;
	logic        avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic        supply_ok_i = 1'h0;
	logic        wp_i = 1'h0;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest, irq, reset_pin_o, reset_pin_oe, mem_access_en, mem_abort, scl_i, sda_i;
	int          mismatches = 0;
	int          cmp_count = 0;
	logic [31:0] d;
	int          n, lim, seed;
	// pull-up on the reset pin; the dut only pulls it low
	wire         rst_pin = reset_pin_oe ? reset_pin_o : 1'h1;

	always #10 clk_sys = ~clk_sys;

	ssw_top #(.HOLD_CYC(HOLD), .WD0_CYC(WD0), .WD1_CYC(600), .WD2_CYC(300)) i_dut (.clk_sys(clk_sys),
		.rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.irq(irq), .supply_ok_i(supply_ok_i), .scl_i(scl_i), .sda_i(sda_i), .wp_i(wp_i),
		.reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe), .mem_access_en(mem_access_en),
		.mem_abort(mem_abort));
	ssw_host_model i_host (.clk_sys(clk_sys), .scl(scl_i), .sda(sda_i));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one transfer held until waitrequest is low at an edge; an idle edge follows
	// waitrequest and read data are taken mid-cycle, where they are settled,
	// and stand unchanged up to the rising edge that completes the transfer
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int   k;
		logic wait_seen;
		k = 0;
		wait_seen = 1'h1;
		rd = 32'h0000_0000;
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(negedge clk_sys);
			wait_seen = avs_waitrequest;
			rd = avs_readdata;
			@(posedge clk_sys);
			k++;
		end while (wait_seen !== 1'h0 && k < 50);
		if (k >= 50) mismatches++;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge clk_sys);
	endtask
	function automatic int wd_cyc(input int s);
		return (s == 0) ? WD0 : (s == 1) ? 600 : 300;
	endfunction
	task automatic wait_oe(input logic lvl, input int lim_in, output int cnt);
		cnt = 0;
		while (reset_pin_oe !== lvl && cnt < lim_in) begin
			@(posedge clk_sys);
			cnt++;
		end
	endtask
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// hang guard, well above the expected run length
	initial begin
		repeat (30000) @(posedge clk_sys);
		mismatches++;
		close_out();
	end
	// main sequence
	initial begin
		seed = $urandom(22378);
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'h1;
		repeat (5) @(posedge clk_sys);
		chk(32'(mem_access_en), 32'h0);
		bus(1'h0, 8'h00, 32'h0, d);
		chk(d, 32'h0000_0003);
		bus(1'h0, 8'h14, 32'h0, d);
		chk(d, 32'h0);
		supply_ok_i <= 1'h1;
		wait_oe(1'h0, HOLD + 50, n);
		chk(32'(n >= HOLD && n <= HOLD + 6), 32'h1);
		// supply loss: interrupt raised, masked, cleared
		bus(1'h1, 8'h10, 32'h0000_000F, d);
		bus(1'h1, 8'h0C, 32'h1, d);
		supply_ok_i <= 1'h0;
		wait_oe(1'h1, 8, n);
		chk(32'(rst_pin), 32'h0);
		chk(32'(mem_access_en), 32'h0);
		bus(1'h0, 8'h08, 32'h0, d);
		chk(d, 32'h1);
		bus(1'h1, 8'h0C, 32'h0, d);
		chk(32'(irq), 32'h0);
		bus(1'h1, 8'h0C, 32'h1, d);
		chk(32'(irq), 32'h1);
		bus(1'h1, 8'h10, 32'h1, d);
		chk(32'(irq), 32'h0);
		// a dip during the hold restarts the wait
		supply_ok_i <= 1'h1;
		repeat (HOLD / 2) @(posedge clk_sys);
		supply_ok_i <= 1'h0;
		repeat (4) @(posedge clk_sys);
		supply_ok_i <= 1'h1;
		wait_oe(1'h0, HOLD + 50, n);
		chk(32'(n >= HOLD && n <= HOLD + 6), 32'h1);
		// each timeout: random kicks keep quiet, silence resets after the limit
		for (int s = 0; s < 3; s++) begin
			lim = wd_cyc(s);
			i_host.send_start();
			bus(1'h1, 8'h00, 32'(s), d);
			repeat (3) begin
				repeat ($urandom_range(lim / 2, 10)) @(posedge clk_sys);
				i_host.send_start();
			end
			chk(32'(reset_pin_oe), 32'h0);
			wait_oe(1'h1, lim + 50, n);
			chk(32'(n >= lim - 20 && n <= lim + 4), 32'h1);
			wait_oe(1'h0, HOLD + 50, n);
			bus(1'h0, 8'h00, 32'h0, d);
			chk(d, 32'(s));
		end
		i_host.send_start();
		bus(1'h1, 8'h00, 32'h0000_0003, d);
		repeat (WD0 + 100) @(posedge clk_sys);
		chk(32'(reset_pin_oe), 32'h0);
		// protect pin with protect enable set drops control writes
		bus(1'h1, 8'h00, 32'h0000_0007, d);
		wp_i <= 1'h1;
		repeat (4) @(posedge clk_sys);
		bus(1'h1, 8'h00, 32'($urandom_range(2, 0)), d);
		bus(1'h0, 8'h00, 32'h0, d);
		chk(d, 32'h0000_0007);
		bus(1'h0, 8'h08, 32'h0, d);
		chk(d & 32'h0000_0008, 32'h0000_0008);
		close_out();
	end
endmodule
